// ===== pkg/lss_pkg.sv
// Shared constants of the link startup sequencer, both ends
// How it works
// - Sequence runs only with application select low
// - Autostart: defaults, then video link on clock
// - No autostart: defaults, link only on command
// - Controller picks video or configuration link enable
// - Controller waits about 3 ms after enable ack
// - Configuration writes replace device defaults, acknowledged
// - Controller enables video later if not yet
// - Video data serialized after video link up
// - System sets upper straps before power-up
// - One-ended configuration inputs are tied low
// - Configuration link holds until video overrides it or its enable bit is cleared
// - Control channel only once a link is up
package lss_pkg;
  // ****************************************************
  // Timing
  // ****************************************************
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned WAIT_US     = 3000;
  localparam int unsigned WAIT_CYC    = WAIT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LOCK_US     = 1000;
  localparam int unsigned LOCK_CYC    = LOCK_US * (CLK_HZ / 1_000_000);
  localparam int          CNT_W       = 18;
  localparam int unsigned BOOT_CYC    = 3;
  // ****************************************************
  // Command map and fields
  // ****************************************************
  localparam logic        ADDR_LINK   = 1'b0;
  localparam logic        ADDR_CFG    = 1'b1;
  localparam int          LNK_SER_BIT = 0;
  localparam int          LNK_CFG_BIT = 1;
  localparam logic [7:0]  LNK_SER_VAL = 8'h01;
  localparam logic [7:0]  LNK_CFG_VAL = 8'h02;
  localparam logic [7:0]  CFG_RESET   = 8'h00;
  localparam int          NOAUTO_BIT  = 1;
  localparam int          DATA_W      = 8;
endpackage : lss_pkg

// ===== pkg/lss_if.sv
// Command and video channel between controller and device
`timescale 1ns/1ps
`default_nettype none
interface lss_if;
  logic       cmd_valid;
  logic       cmd_remote;
  logic       cmd_addr;
  logic [7:0] cmd_data;
  logic       ack;
  logic       ack_ok;
  logic       vid_valid;
  logic [7:0] vid_data;
  logic       vid_ready;
  modport dev (
    input  cmd_valid, cmd_remote, cmd_addr, cmd_data, vid_valid, vid_data,
    output ack, ack_ok, vid_ready
  );
  modport host (
    output cmd_valid, cmd_remote, cmd_addr, cmd_data, vid_valid, vid_data,
    input  ack, ack_ok, vid_ready
  );
endinterface : lss_if
`default_nettype wire

// ===== logic/lss_device.sv
// Serializer end: strap capture, link state machine, serializer
`timescale 1ns/1ps
`default_nettype none
module lss_device #(
  parameter int unsigned LOCK_CYC = lss_pkg::LOCK_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  lss_if.dev              bus,
  input  wire logic       application_select,
  input  wire logic [1:0] upper_config_straps,
  input  wire logic       pclk_present,
  output var  logic       ser_out,
  output var  logic       ser_out_en,
  output var  logic       cfg_link_up,
  output var  logic       vid_link_up,
  output var  logic [7:0] cfg_value,
  output var  logic       rem_wr_valid,
  output var  logic [7:0] rem_wr_data
);
  localparam int CW = lss_pkg::CNT_W;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CLOCK, ST_CUP, ST_VLOCK, ST_VUP
  } lss_state_e;

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;
  logic       app_s;
  logic [1:0] straps_s;
  logic       pclk_s;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
    end else begin
      pin_meta_r <= {pclk_present, upper_config_straps, application_select};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign app_s    = pin_sync_r[0];
  assign straps_s = pin_sync_r[2:1];
  assign pclk_s   = pin_sync_r[3];

  // ****************************************************
  // State
  // ****************************************************
  lss_state_e    st_r,        st_nxt;
  logic [CW-1:0] cnt_r,       cnt_nxt;
  logic [1:0]    boot_cnt_r,  boot_cnt_nxt;
  logic          boot_done_r, boot_done_nxt;
  logic          disp_r,      disp_nxt;
  logic          ser_en_r,    ser_en_nxt;
  logic          cfg_en_r,    cfg_en_nxt;
  logic [7:0]    cfg_val_r,   cfg_val_nxt;
  logic          ack_r,       ack_nxt;
  logic          ack_ok_r,    ack_ok_nxt;
  logic          rem_v_r,     rem_v_nxt;
  logic [7:0]    rem_d_r,     rem_d_nxt;
  logic [7:0]    sh_r,        sh_nxt;
  logic [3:0]    bits_r,      bits_nxt;
  logic          so_r,        so_nxt;
  logic          so_en_r,     so_en_nxt;
  logic          rdy_r,       rdy_nxt;
  logic          cup_r,       cup_nxt;
  logic          vup_r,       vup_nxt;
  logic          link_up;
  logic          vid_go;
  logic          load;

  always_comb begin
    st_nxt        = st_r;
    cnt_nxt       = cnt_r;
    boot_cnt_nxt  = boot_cnt_r;
    boot_done_nxt = boot_done_r;
    disp_nxt      = disp_r;
    ser_en_nxt    = ser_en_r;
    cfg_en_nxt    = cfg_en_r;
    cfg_val_nxt   = cfg_val_r;
    ack_nxt       = 1'b0;
    ack_ok_nxt    = 1'b0;
    rem_v_nxt     = 1'b0;
    rem_d_nxt     = rem_d_r;
    sh_nxt        = sh_r;
    bits_nxt      = bits_r;
    so_nxt        = 1'b0;
    link_up       = (st_r == ST_CUP) || (st_r == ST_VUP);
    vid_go        = ser_en_r && pclk_s;
    load          = bus.vid_valid && rdy_r;

    if (!boot_done_r) begin
      boot_cnt_nxt = boot_cnt_r + 2'h1;
      if (boot_cnt_r == 2'(lss_pkg::BOOT_CYC)) begin
        boot_done_nxt = 1'b1;
        disp_nxt      = !app_s;
        ser_en_nxt    = !straps_s[lss_pkg::NOAUTO_BIT];
      end
    end

    if (bus.cmd_valid && !ack_r) begin
      ack_nxt = 1'b1;
      if (bus.cmd_remote) begin
        ack_ok_nxt = link_up;
        rem_v_nxt  = link_up;
        if (link_up) begin
          rem_d_nxt = bus.cmd_data;
        end
      end else begin
        ack_ok_nxt = 1'b1;
        if (bus.cmd_addr == lss_pkg::ADDR_LINK) begin
          ser_en_nxt = bus.cmd_data[lss_pkg::LNK_SER_BIT];
          cfg_en_nxt = bus.cmd_data[lss_pkg::LNK_CFG_BIT];
        end else begin
          cfg_val_nxt = bus.cmd_data;
        end
      end
    end

    case (st_r)
      ST_IDLE: begin
        if (boot_done_r && disp_r) begin
          if (vid_go) begin
            st_nxt  = ST_VLOCK;
            cnt_nxt = '0;
          end else if (cfg_en_r) begin
            st_nxt  = ST_CLOCK;
            cnt_nxt = '0;
          end
        end
      end
      ST_CLOCK: begin
        if (vid_go) begin
          st_nxt  = ST_VLOCK;
          cnt_nxt = '0;
        end else if (!cfg_en_r) begin
          st_nxt = ST_IDLE;
        end else if (cnt_r == CW'(LOCK_CYC - 1)) begin
          st_nxt = ST_CUP;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_CUP: begin
        if (vid_go) begin
          st_nxt  = ST_VLOCK;
          cnt_nxt = '0;
        end else if (!cfg_en_r) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_VLOCK: begin
        if (!vid_go) begin
          st_nxt = ST_IDLE;
        end else if (cnt_r == CW'(LOCK_CYC - 1)) begin
          st_nxt = ST_VUP;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_VUP: begin
        if (!vid_go) begin
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase

    if (load) begin
      so_nxt   = bus.vid_data[0];
      sh_nxt   = bus.vid_data >> 1;
      bits_nxt = 4'h7;
    end else if (bits_r != 4'h0) begin
      so_nxt   = sh_r[0];
      sh_nxt   = sh_r >> 1;
      bits_nxt = bits_r - 4'h1;
    end
    if (st_nxt != ST_VUP) begin
      bits_nxt = 4'h0;
    end
    rdy_nxt   = (st_nxt == ST_VUP) && (bits_nxt == 4'h0);
    so_en_nxt = (st_nxt != ST_IDLE);
    cup_nxt   = (st_nxt == ST_CUP);
    vup_nxt   = (st_nxt == ST_VUP);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r        <= ST_IDLE;
      cnt_r       <= '0;
      boot_cnt_r  <= 2'h0;
      boot_done_r <= 1'b0;
      disp_r      <= 1'b0;
      ser_en_r    <= 1'b0;
      cfg_en_r    <= 1'b0;
      cfg_val_r   <= lss_pkg::CFG_RESET;
      ack_r       <= 1'b0;
      ack_ok_r    <= 1'b0;
      rem_v_r     <= 1'b0;
      rem_d_r     <= 8'h00;
      sh_r        <= 8'h00;
      bits_r      <= 4'h0;
      so_r        <= 1'b0;
      so_en_r     <= 1'b0;
      rdy_r       <= 1'b0;
      cup_r       <= 1'b0;
      vup_r       <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      cnt_r       <= cnt_nxt;
      boot_cnt_r  <= boot_cnt_nxt;
      boot_done_r <= boot_done_nxt;
      disp_r      <= disp_nxt;
      ser_en_r    <= ser_en_nxt;
      cfg_en_r    <= cfg_en_nxt;
      cfg_val_r   <= cfg_val_nxt;
      ack_r       <= ack_nxt;
      ack_ok_r    <= ack_ok_nxt;
      rem_v_r     <= rem_v_nxt;
      rem_d_r     <= rem_d_nxt;
      sh_r        <= sh_nxt;
      bits_r      <= bits_nxt;
      so_r        <= so_nxt;
      so_en_r     <= so_en_nxt;
      rdy_r       <= rdy_nxt;
      cup_r       <= cup_nxt;
      vup_r       <= vup_nxt;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign bus.ack       = ack_r;
  assign bus.ack_ok    = ack_ok_r;
  assign bus.vid_ready = rdy_r;
  assign ser_out       = so_r;
  assign ser_out_en    = so_en_r;
  assign cfg_link_up   = cup_r;
  assign vid_link_up   = vup_r;
  assign cfg_value     = cfg_val_r;
  assign rem_wr_valid  = rem_v_r;
  assign rem_wr_data   = rem_d_r;
endmodule : lss_device
`default_nettype wire

// ===== logic/lss_host.sv
// Controller end: startup command sequence and video source
`timescale 1ns/1ps
`default_nettype none
module lss_host #(
  parameter int unsigned WAIT_CYC = lss_pkg::WAIT_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  lss_if.host             bus,
  input  wire logic       start,
  input  wire logic       pclk_ok,
  input  wire logic [7:0] dev_cfg,
  input  wire logic [7:0] rem_cfg,
  input  wire logic       usr_vid_valid,
  input  wire logic [7:0] usr_vid_data,
  output var  logic       usr_vid_ready,
  output var  logic       busy,
  output var  logic       streaming,
  output var  logic       rem_nak
);
  localparam int CW = lss_pkg::CNT_W;

  typedef enum logic [2:0] {
    H_IDLE, H_LINK, H_WAIT, H_DCFG, H_RCFG, H_SER, H_RUN
  } lss_hstate_e;

  // ****************************************************
  // Pin synchroniser
  // ****************************************************
  logic pclk_meta_r;
  logic pclk_s_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pclk_meta_r <= 1'b0;
      pclk_s_r    <= 1'b0;
    end else begin
      pclk_meta_r <= pclk_ok;
      pclk_s_r    <= pclk_meta_r;
    end
  end

  // ****************************************************
  // Sequence
  // ****************************************************
  lss_hstate_e   st_r,     st_nxt;
  logic [CW-1:0] cnt_r,    cnt_nxt;
  logic          vid_on_r, vid_on_nxt;
  logic          cfgd_r,   cfgd_nxt;
  logic [7:0]    dcfg_r,   dcfg_nxt;
  logic [7:0]    rcfg_r,   rcfg_nxt;
  logic          cv_r,     cv_nxt;
  logic          crem_r,   crem_nxt;
  logic          caddr_r,  caddr_nxt;
  logic [7:0]    cdata_r,  cdata_nxt;
  logic          nak_r,    nak_nxt;
  logic          vv_r,     vv_nxt;
  logic [7:0]    vd_r,     vd_nxt;
  logic          urdy_r,   urdy_nxt;
  logic          busy_r,   busy_nxt;
  logic          strm_r,   strm_nxt;

  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    vid_on_nxt = vid_on_r;
    cfgd_nxt   = cfgd_r;
    dcfg_nxt   = dcfg_r;
    rcfg_nxt   = rcfg_r;
    nak_nxt    = nak_r;
    vv_nxt     = vv_r;
    vd_nxt     = vd_r;
    case (st_r)
      H_IDLE: begin
        if (start) begin
          st_nxt     = H_LINK;
          dcfg_nxt   = dev_cfg;
          rcfg_nxt   = rem_cfg;
          nak_nxt    = 1'b0;
          cfgd_nxt   = 1'b0;
          vid_on_nxt = pclk_s_r;
        end
      end
      H_LINK: begin
        if (bus.ack) begin
          st_nxt  = H_WAIT;
          cnt_nxt = '0;
        end
      end
      H_WAIT: begin
        if (cnt_r == CW'(WAIT_CYC - 1)) begin
          st_nxt = cfgd_r ? H_RUN : H_DCFG;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      H_DCFG: begin
        if (bus.ack) begin
          st_nxt = H_RCFG;
        end
      end
      H_RCFG: begin
        if (bus.ack) begin
          cfgd_nxt = 1'b1;
          nak_nxt  = !bus.ack_ok;
          st_nxt   = vid_on_r ? H_RUN : H_SER;
        end
      end
      H_SER: begin
        if (bus.ack) begin
          vid_on_nxt = 1'b1;
          st_nxt     = H_WAIT;
          cnt_nxt    = '0;
        end
      end
      H_RUN: begin
        if (start) begin
          st_nxt = H_IDLE;
        end
      end
      default: begin
        st_nxt = H_IDLE;
      end
    endcase

    if (vv_r && bus.vid_ready) begin
      vv_nxt = 1'b0;
    end
    if (usr_vid_valid && urdy_r) begin
      vv_nxt = 1'b1;
      vd_nxt = usr_vid_data;
    end
    if (st_nxt != H_RUN) begin
      vv_nxt = 1'b0;
    end
    urdy_nxt = (st_nxt == H_RUN) && !vv_nxt;
    busy_nxt = (st_nxt != H_IDLE) && (st_nxt != H_RUN);
    strm_nxt = (st_nxt == H_RUN);

    cv_nxt    = 1'b0;
    crem_nxt  = 1'b0;
    caddr_nxt = lss_pkg::ADDR_LINK;
    cdata_nxt = 8'h00;
    if (st_nxt == H_LINK) begin
      cv_nxt    = 1'b1;
      cdata_nxt = vid_on_nxt ? lss_pkg::LNK_SER_VAL : lss_pkg::LNK_CFG_VAL;
    end else if (st_nxt == H_DCFG) begin
      cv_nxt    = 1'b1;
      caddr_nxt = lss_pkg::ADDR_CFG;
      cdata_nxt = dcfg_nxt;
    end else if (st_nxt == H_RCFG) begin
      cv_nxt    = 1'b1;
      crem_nxt  = 1'b1;
      caddr_nxt = lss_pkg::ADDR_CFG;
      cdata_nxt = rcfg_nxt;
    end else if (st_nxt == H_SER) begin
      cv_nxt    = 1'b1;
      cdata_nxt = lss_pkg::LNK_SER_VAL;
    end
    if (bus.ack && (st_nxt == st_r)) begin
      cv_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r     <= H_IDLE;
      cnt_r    <= '0;
      vid_on_r <= 1'b0;
      cfgd_r   <= 1'b0;
      dcfg_r   <= 8'h00;
      rcfg_r   <= 8'h00;
      cv_r     <= 1'b0;
      crem_r   <= 1'b0;
      caddr_r  <= 1'b0;
      cdata_r  <= 8'h00;
      nak_r    <= 1'b0;
      vv_r     <= 1'b0;
      vd_r     <= 8'h00;
      urdy_r   <= 1'b0;
      busy_r   <= 1'b0;
      strm_r   <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      vid_on_r <= vid_on_nxt;
      cfgd_r   <= cfgd_nxt;
      dcfg_r   <= dcfg_nxt;
      rcfg_r   <= rcfg_nxt;
      cv_r     <= cv_nxt;
      crem_r   <= crem_nxt;
      caddr_r  <= caddr_nxt;
      cdata_r  <= cdata_nxt;
      nak_r    <= nak_nxt;
      vv_r     <= vv_nxt;
      vd_r     <= vd_nxt;
      urdy_r   <= urdy_nxt;
      busy_r   <= busy_nxt;
      strm_r   <= strm_nxt;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign bus.cmd_valid  = cv_r;
  assign bus.cmd_remote = crem_r;
  assign bus.cmd_addr   = caddr_r;
  assign bus.cmd_data   = cdata_r;
  assign bus.vid_valid  = vv_r;
  assign bus.vid_data   = vd_r;
  assign usr_vid_ready  = urdy_r;
  assign busy           = busy_r;
  assign streaming      = strm_r;
  assign rem_nak        = nak_r;
endmodule : lss_host
`default_nettype wire

// ===== test/lss_link_asserts.sv
// Checker for the command and video channel of the startup sequencer
`timescale 1ns/1ps
`default_nettype none
module lss_link_asserts #(
  parameter int unsigned WAIT_CYC = lss_pkg::WAIT_CYC
) (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       cmd_valid,
  input wire logic       cmd_remote,
  input wire logic       cmd_addr,
  input wire logic [7:0] cmd_data,
  input wire logic       ack,
  input wire logic       ack_ok,
  input wire logic       vid_valid,
  input wire logic       vid_ready
);
  // ****************************************************
  // Helper state
  // ****************************************************
  logic        link_ack;
  logic        seen_r;
  logic        seen_nxt;
  logic [31:0] gap_r;
  logic [31:0] gap_nxt;
  assign link_ack = ack && !cmd_remote && cmd_addr == lss_pkg::ADDR_LINK;
  always_comb begin
    seen_nxt = seen_r | (link_ack & ack_ok);
    gap_nxt = (gap_r < WAIT_CYC) ? gap_r + 32'h1 : gap_r;
    if (link_ack) begin
      gap_nxt = 32'h0;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seen_r <= 1'b0;
      gap_r <= WAIT_CYC;
    end else begin
      seen_r <= seen_nxt;
      gap_r <= gap_nxt;
    end
  end
  // ****************************************************
  // Properties
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence take_s;
    vid_valid && vid_ready;
  endsequence
  sequence gap_s;
    !vid_ready [*7] ##1 vid_ready;
  endsequence
  sequence new_cmd_s;
    cmd_valid && (!$past(cmd_valid) || $past(ack));
  endsequence
  a_ack_one_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_after_take: assert property (cmd_valid && !ack |=> ack)
    else $error("command not acknowledged next cycle");
  a_ack_has_cmd: assert property (ack |-> $past(cmd_valid))
    else $error("ack without command");
  a_cmd_held: assert property (cmd_valid && !ack |=> cmd_valid
    && $stable(cmd_data) && $stable(cmd_addr) && $stable(cmd_remote))
    else $error("command changed before ack");
  a_local_ack_ok: assert property (ack && !cmd_remote |-> ack_ok)
    else $error("local write refused");
  a_word_gap: assert property (take_s |=> gap_s)
    else $error("video ready spacing wrong");
  a_video_after_link: assert property (vid_valid |-> seen_r)
    else $error("video before link enable acked");
  a_remote_after_link: assert property (cmd_valid && cmd_remote |-> seen_r)
    else $error("remote write before link enable");
  a_link_wait: assert property (new_cmd_s |-> gap_r + 2 >= WAIT_CYC)
    else $error("command too soon after link enable");
endmodule // lss_link_asserts
`default_nettype wire

// ===== test/tb_link_startup_sequencer.sv
// Testbench joining controller and device ends of the sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_link_startup_sequencer;
  localparam int unsigned LOCK_T = 8;
  localparam int unsigned WAIT_T = 20;
  localparam int          LIMIT  = 3000;
  logic       clk;
  logic       reset_n;
  logic       app_sel;
  logic [1:0] straps;
  logic       pclk;
  logic       start;
  logic [7:0] dev_cfg;
  logic [7:0] rem_cfg;
  logic       usr_valid;
  logic [7:0] usr_data;
  logic       usr_ready;
  logic       ser_out;
  logic       ser_out_en;
  logic       cfg_link_up;
  logic       vid_link_up;
  logic [7:0] cfg_value;
  logic       rem_wr_valid;
  logic [7:0] rem_wr_data;
  logic [7:0] rem_seen;
  logic       busy;
  logic       streaming;
  logic       rem_nak;
  int         error_cnt;
  int         checks_done;
  int         cyc;
  int         n;
  lss_if bus_inst ();
  lss_device #(.LOCK_CYC(LOCK_T)) lss_device_inst (.clk(clk),
    .reset_n(reset_n), .bus(bus_inst), .application_select(app_sel),
    .upper_config_straps(straps), .pclk_present(pclk), .ser_out(ser_out),
    .ser_out_en(ser_out_en), .cfg_link_up(cfg_link_up),
    .vid_link_up(vid_link_up), .cfg_value(cfg_value),
    .rem_wr_valid(rem_wr_valid), .rem_wr_data(rem_wr_data));
  lss_host #(.WAIT_CYC(WAIT_T)) lss_host_inst (.clk(clk), .reset_n(reset_n),
    .bus(bus_inst), .start(start), .pclk_ok(pclk), .dev_cfg(dev_cfg),
    .rem_cfg(rem_cfg), .usr_vid_valid(usr_valid), .usr_vid_data(usr_data),
    .usr_vid_ready(usr_ready), .busy(busy), .streaming(streaming),
    .rem_nak(rem_nak));
  lss_link_asserts #(.WAIT_CYC(WAIT_T)) lss_link_asserts_inst (.clk(clk),
    .reset_n(reset_n), .cmd_valid(bus_inst.cmd_valid),
    .cmd_remote(bus_inst.cmd_remote), .cmd_addr(bus_inst.cmd_addr),
    .cmd_data(bus_inst.cmd_data), .ack(bus_inst.ack),
    .ack_ok(bus_inst.ack_ok), .vid_valid(bus_inst.vid_valid),
    .vid_ready(bus_inst.vid_ready));
  // ****************************************************
  // Clock, timeout, remote write capture
  // ****************************************************
  initial clk = 1'b0;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (rem_wr_valid === 1'b1) begin
      rem_seen <= rem_wr_data;
    end
    if (cyc == LIMIT) begin
      error_cnt++;
      results();
    end
  end
  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic boot(input logic sel, input logic [1:0] st, input logic pc);
    reset_n = 1'b0;
    app_sel = sel;
    straps = st;
    pclk = pc;
    start = 1'b0;
    usr_valid = 1'b0;
    rem_seen = 8'h00;
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
  endtask
  task automatic kick(input logic [7:0] dc, input logic [7:0] rc);
    dev_cfg = dc;
    rem_cfg = rc;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
  endtask
  task automatic t_stream(input logic [7:0] d);
    logic [7:0] got;
    usr_data = d;
    usr_valid = 1'b1;
    for (n = 0; n < 50 && usr_ready !== 1'b1; n++) @(posedge clk) #1;
    @(posedge clk);
    #1 usr_valid = 1'b0;
    for (n = 0; n < 50 && !(bus_inst.vid_valid && bus_inst.vid_ready); n++)
      @(posedge clk) #1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      #1 got[i] = ser_out;
      @(posedge clk);
    end
    #1 chk("serial word", d, got);
  endtask
  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_idle();
    boot(1'b0, 2'b10, 1'b1);
    repeat (20) @(posedge clk);
    #1 chk("idle output enable", 8'h00, {7'h00, ser_out_en});
    chk("idle video link", 8'h00, {7'h00, vid_link_up});
    chk("default config", 8'h00, cfg_value);
  endtask
  task automatic t_app_sel();
    boot(1'b1, 2'b00, 1'b1);
    repeat (40) @(posedge clk);
    #1 chk("app select video", 8'h00, {7'h00, vid_link_up});
    chk("app select enable", 8'h00, {7'h00, ser_out_en});
    kick(8'h11, 8'h22);
    for (n = 0; n < 300 && streaming !== 1'b1; n++) @(posedge clk) #1;
    chk("refused remote nak", 8'h01, {7'h00, rem_nak});
    chk("refused remote data", 8'h00, rem_seen);
    chk("app select local config", 8'h11, cfg_value);
    chk("app select held idle", 8'h00, {7'h00, ser_out_en});
  endtask
  task automatic t_auto();
    boot(1'b0, 2'b00, 1'b1);
    for (n = 0; n < 40 && vid_link_up !== 1'b1; n++) @(posedge clk) #1;
    chk("autostart video", 8'h01, {7'h00, vid_link_up});
    chk("autostart config", 8'h00, cfg_value);
    kick(8'h3c, 8'hc3);
    for (n = 0; n < 300 && streaming !== 1'b1; n++) @(posedge clk) #1;
    chk("auto streaming", 8'h01, {7'h00, streaming});
    chk("device config", 8'h3c, cfg_value);
    chk("remote config", 8'hc3, rem_seen);
    chk("remote nak", 8'h00, {7'h00, rem_nak});
    chk("run not busy", 8'h00, {7'h00, busy});
    t_stream(8'h96);
  endtask
  task automatic t_cfg();
    boot(1'b0, 2'b10, 1'b0);
    kick(8'h5a, 8'ha5);
    for (n = 0; n < 60 && cfg_link_up !== 1'b1; n++) @(posedge clk) #1;
    chk("config link", 8'h01, {7'h00, cfg_link_up});
    chk("config no video", 8'h00, {7'h00, vid_link_up});
    chk("host waiting", 8'h01, {7'h00, busy});
    chk("config before wait", 8'h00, cfg_value);
    pclk = 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("config held", 8'h00, {7'h00, vid_link_up});
    for (n = 0; n < 300 && streaming !== 1'b1; n++) @(posedge clk) #1;
    chk("late video link", 8'h01, {7'h00, vid_link_up});
    chk("device config", 8'h5a, cfg_value);
    chk("remote config", 8'ha5, rem_seen);
    t_stream(8'h5c);
    t_stream(8'h81);
  endtask
  task automatic t_loss();
    pclk = 1'b0;
    for (n = 0; n < 20 && ser_out_en !== 1'b0; n++) @(posedge clk) #1;
    chk("loss video", 8'h00, {7'h00, vid_link_up});
    chk("loss enable", 8'h00, {7'h00, ser_out_en});
    chk("loss ready", 8'h00, {7'h00, bus_inst.vid_ready});
  endtask
  // ****************************************************
  // Main sequence and verdict
  // ****************************************************
  task automatic results();
    $display("Checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    error_cnt = 0;
    checks_done = 0;
    cyc = 0;
    dev_cfg = 8'h00;
    rem_cfg = 8'h00;
    usr_data = 8'h00;
    t_idle();
    t_app_sel();
    t_auto();
    t_loss();
    t_cfg();
    t_loss();
    results();
  end
endmodule // tb_link_startup_sequencer
`default_nettype wire
